// >>> rtl/servo_io_function_mapper.v
`timescale 1ns/1ps
`default_nettype none
`include "servo_io_map.vh"

module servo_io_function_mapper #(
  parameter SEALED_VARIANT = 0
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Drive conditions, same clock
  input  wire [17:0] drive_cond,
  input  wire        fault_event,
  input  wire        motion_req,
  // Discrete pins, high level means open
  input  wire        enable_pin,
  input  wire        alarm_clear_input,
  // Results
  output reg  [2:0]  out_conduct,
  output reg         windings_on,
  output reg         alarm_active,
  output reg         motion_accept,
  output reg         motion_reject,
  output reg         irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam [5:0] SEL0_RST = SEALED_VARIANT ? `RST_SEAL_SEL0 : `RST_SIX_SEL0;
  localparam [5:0] SEL1_RST = SEALED_VARIANT ? `RST_SEAL_SEL1 : `RST_SIX_SEL1;
  localparam [5:0] SEL2_RST = SEALED_VARIANT ? `RST_SEAL_SEL2 : `RST_SIX_SEL2;

  reg  [5:0]  sel_q [0:2];
  reg  [1:0]  en_sel_q;
  reg  [2:0]  clr_sel_q;
  reg  [2:0]  gp_out_q;
  reg  [2:0]  irq_stat_q;
  reg  [2:0]  irq_mask_q;
  reg  [7:0]  aw_addr_q;
  reg         aw_full_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_full_q;
  reg  [31:0] rd_mux;
  reg         rd_hit;

  // Pin synchronisers
  reg         en_s1_q;
  reg         en_s2_q;
  reg         clr_s1_q;
  reg         clr_s2_q;
  reg         clr_prev_q;

  wire        wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire        wr_hit = (aw_addr_q == `OFS_OUT_SEL0) | (aw_addr_q == `OFS_OUT_SEL1) |
                       (aw_addr_q == `OFS_OUT_SEL2) | (aw_addr_q == `OFS_IN_CFG) |
                       (aw_addr_q == `OFS_GP_OUT) | (aw_addr_q == `OFS_IRQ_MASK);
  wire        ar_go = s_axi_arvalid & s_axi_arready;

  // ----------------------------------------------------------------
  // Alarm clear edge and enable decode
  // ----------------------------------------------------------------
  wire clr_closed      = ~clr_s2_q;
  wire clr_fall        = clr_prev_q & ~clr_s2_q;   // open to closed
  wire clr_rise        = ~clr_prev_q & clr_s2_q;   // closed to open
  wire clr_edge        = ((clr_sel_q == `CLR_CLOSED) & clr_fall) |
                         ((clr_sel_q == `CLR_OPEN) & clr_rise);
  wire alarm_clear_hit = alarm_active & clr_edge;
  wire en_closed       = ~en_s2_q;
  reg  wind_d;

  always @* begin
    case (en_sel_q)
      `EN_CLOSED: wind_d = en_closed;
      `EN_OPEN:   wind_d = ~en_closed;
      // No enable pin assigned: alarm clear level stands in
      `EN_NONE:   wind_d = (clr_sel_q == `CLR_OPEN) ? ~clr_closed : clr_closed;
      default:    wind_d = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Output mapping
  // ----------------------------------------------------------------
  wire [17:0] cond;
  assign cond = {drive_cond[17:4], windings_on, drive_cond[2:1], alarm_active};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out
      wire [5:0] code  = sel_q[g];
      wire [5:0] cm1   = code - 6'h01;
      wire [4:0] idx   = cm1[5:1];
      reg        c_d;
      always @* begin
        if (code == `CODE_PLAIN) begin
          c_d = gp_out_q[g];
        end else if (code == `CODE_BRAKE_OPEN || code > `CODE_MAX) begin
          c_d = 1'b0;
        end else begin
          // Odd code conducts when true, even when false
          c_d = code[0] ? cond[idx] : ~cond[idx];
        end
      end
      always @(posedge aclk) begin
        if (!aresetn) begin
          out_conduct[g] <= 1'b0;
        end else begin
          out_conduct[g] <= c_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_OUT_SEL0: rd_mux[5:0] = sel_q[0];
      `OFS_OUT_SEL1: rd_mux[5:0] = sel_q[1];
      `OFS_OUT_SEL2: rd_mux[5:0] = sel_q[2];
      `OFS_IN_CFG: begin
        rd_mux[1:0]  = en_sel_q;
        rd_mux[10:8] = clr_sel_q;
      end
      `OFS_GP_OUT:   rd_mux[2:0] = gp_out_q;
      `OFS_STATUS:   rd_mux[6:0] = {en_s2_q, clr_s2_q, out_conduct, alarm_active, windings_on};
      `OFS_IRQ_STAT: rd_mux[2:0] = irq_stat_q;
      `OFS_IRQ_MASK: rd_mux[2:0] = irq_mask_q;
      default:       rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  wire [2:0] irq_ev = {motion_req & ~windings_on, alarm_clear_hit, fault_event};

  always @(posedge aclk) begin
    if (!aresetn) begin
      en_s1_q       <= 1'b1;
      en_s2_q       <= 1'b1;
      clr_s1_q      <= 1'b1;
      clr_s2_q      <= 1'b1;
      clr_prev_q    <= 1'b1;
      windings_on   <= 1'b0;
      alarm_active  <= 1'b0;
      motion_accept <= 1'b0;
      motion_reject <= 1'b0;
      irq_stat_q    <= 3'h0;
      irq           <= 1'b0;
    end else begin
      en_s1_q    <= enable_pin;
      en_s2_q    <= en_s1_q;
      clr_s1_q   <= alarm_clear_input;
      clr_s2_q   <= clr_s1_q;
      clr_prev_q <= clr_s2_q;
      windings_on <= wind_d;
      // New fault wins over a clear in the same cycle
      if (fault_event) begin
        alarm_active <= 1'b1;
      end else if (alarm_clear_hit) begin
        alarm_active <= 1'b0;
      end
      motion_accept <= motion_req & windings_on;
      motion_reject <= motion_req & ~windings_on;
      // Read clears, but a same-cycle event survives
      if (ar_go && s_axi_araddr == `OFS_IRQ_STAT) begin
        irq_stat_q <= irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      sel_q[0]      <= SEL0_RST;
      sel_q[1]      <= SEL1_RST;
      sel_q[2]      <= SEL2_RST;
      en_sel_q      <= `RST_EN_SEL;
      clr_sel_q     <= `RST_CLR_SEL;
      gp_out_q      <= 3'h0;
      irq_mask_q    <= 3'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (w_strb_q[0]) begin
          case (aw_addr_q)
            `OFS_OUT_SEL0: sel_q[0] <= w_data_q[5:0];
            `OFS_OUT_SEL1: sel_q[1] <= w_data_q[5:0];
            `OFS_OUT_SEL2: sel_q[2] <= w_data_q[5:0];
            `OFS_IN_CFG:   en_sel_q <= w_data_q[1:0];
            `OFS_GP_OUT:   gp_out_q <= w_data_q[2:0];
            `OFS_IRQ_MASK: irq_mask_q <= w_data_q[2:0];
            default: ;
          endcase
        end
        if (w_strb_q[1] && aw_addr_q == `OFS_IN_CFG) begin
          clr_sel_q <= w_data_q[10:8];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // servo_io_function_mapper

`default_nettype wire

// >>> pkg/servo_io_map.vh
`ifndef SERVO_IO_MAP_VH
`define SERVO_IO_MAP_VH

// Register byte offsets
`define OFS_OUT_SEL0    8'h00
`define OFS_OUT_SEL1    8'h04
`define OFS_OUT_SEL2    8'h08
`define OFS_IN_CFG      8'h0C
`define OFS_GP_OUT      8'h10
`define OFS_STATUS      8'h14
`define OFS_IRQ_STAT    8'h18
`define OFS_IRQ_MASK    8'h1C

// Output function codes
`define CODE_W          6
`define CODE_PLAIN      6'h00
`define CODE_BRAKE_OPEN 6'h06
`define CODE_MAX        6'h24

// Condition indices, (code-1)/2
`define COND_ERROR      0
`define COND_ENERGIZED  3
`define COND_N          18

// Reset codes per variant
`define RST_SIX_SEL0    6'h07
`define RST_SIX_SEL1    6'h02
`define RST_SIX_SEL2    6'h09
`define RST_SEAL_SEL0   6'h02
`define RST_SEAL_SEL1   6'h09
`define RST_SEAL_SEL2   6'h00

// Input function codes
`define EN_NONE         2'h0
`define EN_CLOSED       2'h1
`define EN_OPEN         2'h2
`define CLR_CLOSED      3'h3
`define CLR_OPEN        3'h4
`define RST_EN_SEL      2'h1
`define RST_CLR_SEL     3'h3

// IN_CFG fields
`define CFG_EN_LSB      0
`define CFG_CLR_LSB     8

// Interrupt bits
`define IRQ_ALARM_SET   0
`define IRQ_ALARM_CLR   1
`define IRQ_REJECT      2
`define IRQ_W           3

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> tb/servo_io_function_mapper_properties.sv
`timescale 1ns/1ps
`default_nettype none
module servo_io_props #(
  parameter SEALED_VARIANT = 0
) (
  // Clock, reset and bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Drive side
  input wire logic        fault_event,
  input wire logic        motion_req,
  input wire logic        alarm_clear_input,
  input wire logic [2:0]  out_conduct,
  input wire logic        windings_on,
  input wire logic        alarm_active,
  input wire logic        motion_accept,
  input wire logic        motion_reject
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------
  // Checks
  // ----------------
  a_accept_on: assert property (motion_req && windings_on |=> motion_accept)
    else $error("motion accept missing");
  a_reject_off: assert property (
    motion_req && !windings_on |=> motion_reject && !motion_accept)
    else $error("motion reject missing");
  a_no_request: assert property (!motion_req |=> !motion_accept && !motion_reject)
    else $error("motion answer without request");
  // Pin seen four samples back, after two sync stages and the edge compare
  a_clear_edge: assert property (
    $fell(alarm_active) |-> $past(alarm_clear_input, 4) != $past(alarm_clear_input, 3))
    else $error("alarm cleared without pin edge");
  a_fault_sets: assert property (fault_event |=> alarm_active)
    else $error("fault did not set alarm");
  a_reset_map: assert property (
    $rose(aresetn) |=> out_conduct[0] == (SEALED_VARIANT != 0)
      && (SEALED_VARIANT != 0 || out_conduct[1]))
    else $error("output map after reset wrong");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_clear: cover property ($fell(alarm_active));
  c_accept: cover property (motion_req && windings_on);
  c_reject: cover property (motion_req && !windings_on);
endmodule // servo_io_props
`default_nettype wire

// >>> tb/host_pins.sv
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  // Requests from the bench
  input  wire logic aclk,
  input  wire logic en_closed,
  input  wire logic idle_closed,
  input  wire logic act,
  // Discrete lines, high is open
  output var  logic enable_pin,
  output var  logic alarm_clear_input
);
  // ----------------
  // Pin drivers
  // ----------------
  initial begin
    enable_pin = 1'b1;
    alarm_clear_input = 1'b1;
  end
  always @(posedge aclk) begin
    enable_pin <= !en_closed;
    alarm_clear_input <= !(idle_closed ^ act);
  end
endmodule // host_pins
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_io_map.vh"
module tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, fault_event, motion_req, en_closed, idle_closed, act, wd;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        windings_on, alarm_active, motion_accept, motion_reject;
  logic        enable_pin, alarm_clear_input;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  out_conduct;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [17:0] drive_cond, k;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd, seed, d;
  int          error_cnt, checked;
  servo_io_function_mapper i_servo_io_function_mapper (.*);
  host_pins i_host_pins (.*);
  always #25 aclk = !aclk;
  // ----------------
  // Bench tasks
  // ----------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic model(input int c, input logic [17:0] k, input logic g);
    if (c == 0) return g;
    if (c == 6 || c > 36) return 1'b0;
    return c % 2 ? k[(c - 1) / 2] : !k[(c - 1) / 2];
  endfunction
  task automatic pause(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 50) begin
      error_cnt++;
      results();
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic pa, pw;
    n = 0;
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((pa || pw) && n < 50) begin
      @(posedge aclk);
      n++;
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
    guard(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    v = s_axi_rdata;
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
    guard(n);
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     fault_event, motion_req, en_closed, idle_closed, act, s_axi_awaddr, s_axi_araddr,
     drive_cond, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'h3766;
    pause(3);
    aresetn <= 1'b1;
    pause(2);
    chk("out", 3'h2, out_conduct);
    for (int i = 0; i < 3; i++) begin
      rd(4 * i, `RESP_OKAY, d);
      chk("sel", i == 0 ? 7 : i == 1 ? 2 : 9, d);
    end
    rd(8'h20, `RESP_SLVERR, d);
    chk("rdata", 0, d);
    wr(`OFS_STATUS, 32'h1, `RESP_SLVERR);
    rnd = xs();
    wr(`OFS_GP_OUT, rnd[2:0], `RESP_OKAY);
    wd = rnd[0];
    // Alarm and windings both off here, so the bench forces their bits low
    for (int c = 0; c < 38; c++) begin
      wr(`OFS_OUT_SEL0, c, `RESP_OKAY);
      repeat (3) begin
        rnd = xs();
        drive_cond <= rnd[17:0];
        k = {rnd[17:4], 1'b0, rnd[2:1], 1'b0};
        pause(2);
        chk("out", model(c, k, wd), out_conduct[0]);
      end
    end
    for (int s = 0; s < 3; s++) begin
      wr(`OFS_IN_CFG, 32'h300 | s, `RESP_OKAY);
      for (int p = 0; p < 2; p++) begin
        en_closed <= p;
        act <= p;
        pause(6);
        motion_req <= 1'b1;
        @(posedge aclk);
        motion_req <= 1'b0;
        @(posedge aclk);
        wd = s == 2 ? !p : p;
        chk("windings", wd, windings_on);
        chk("accept", wd, motion_accept);
        chk("reject", !wd, motion_reject);
      end
    end
    for (int s = 3; s < 5; s++) begin
      wr(`OFS_IN_CFG, (s << 8) | 1, `RESP_OKAY);
      wr(`OFS_IRQ_MASK, s == 3 ? 7 : 0, `RESP_OKAY);
      wr(`OFS_OUT_SEL1, 32'h1, `RESP_OKAY);
      wr(`OFS_OUT_SEL2, 32'h7, `RESP_OKAY);
      rd(`OFS_IRQ_STAT, `RESP_OKAY, d);
      idle_closed <= s == 4;
      act <= 1'b1;
      pause(6);
      fault_event <= 1'b1;
      @(posedge aclk);
      fault_event <= 1'b0;
      for (int j = 0; j < 3; j++) begin
        pause(6);
        chk("alarm", j < 2, alarm_active);
        chk("out_two", j < 2, out_conduct[1]);
        chk("out_three", 1, out_conduct[2]);
        if (j == 0) chk("irq", s == 3, irq);
        act <= !act;
      end
      rd(`OFS_IRQ_STAT, `RESP_OKAY, d);
      chk("irq_stat", 3'h3, d);
      pause(3);
      chk("irq", 0, irq);
    end
    results();
  end
endmodule // tb
bind servo_io_function_mapper servo_io_props #(.SEALED_VARIANT(SEALED_VARIANT)) i_props (.*);
`default_nettype wire
